// [rtl/nvw_pkg.sv]
// Package for the serial nonvolatile byte memory command layer.
// Assumes an SPI master on the pins and a free-running system clock.
package nvw_pkg;

   // ---------------------------------------------------------------
   // Command bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] MEM_READ_CMD = 8'h03;
   localparam logic [7:0] MEM_WRITE_CMD = 8'h02;

   // ---------------------------------------------------------------
   // Status register layout and reset values
   // ---------------------------------------------------------------
   localparam int PROTECT_PIN_ENABLE_POS = 7;
   localparam int BLOCK_PROTECT_HI_POS = 3;
   localparam int BLOCK_PROTECT_LO_POS = 2;
   localparam int WRITE_LATCH_FLAG_POS = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [1:0] BLOCK_PROTECT_RESET = 2'h0;
   localparam logic PROTECT_PIN_ENABLE_RESET = 1'b0;
   localparam logic WRITE_LATCH_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Array geometry and protected ranges
   // ---------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int MEM_DEPTH = 32768;
   localparam logic [14:0] ADDR_RESET = 15'h0000;
   localparam logic [14:0] ADDR_LAST = 15'h7fff;
   localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
   localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ---------------------------------------------------------------
   // Frame phases and state carriers
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_WR_DATA, PH_RD_DATA,
      PH_SR_WRITE, PH_SR_READ, PH_IGNORE, PH_DONE
   } nvw_phase_e;

   typedef struct packed {
      logic tog_seen;
      nvw_phase_e phase;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic [14:0] addr;
      logic [7:0] obuf;
      logic drive;
      logic is_read;
      logic [1:0] bp;
      logic protect_pin_enable;
      logic act_set;
      logic act_clr;
      logic stop;
      logic wel_s1;
      logic wel_s2;
      logic wp_s1;
      logic wp_s2;
   } nvw_link_s;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic write_latch_flag;
   } nvw_sys_s;

endpackage

// [rtl/nvw_memory.sv]
// Command layer of an SPI serial nonvolatile byte memory, 32K x 8.
// Assumes SPI mode 0 or 3 master; chip select stays high for at least
// four system clocks between frames so the latch update can land.
//
// Operation
// - Write latch comes up cleared after power-up reset.
// - Only the set-latch command sets the write latch flag.
// - Latch clears at chip select rise after clear, status write or memory write.
// - Clear-latch command blocks writes; status read then shows latch zero.
// - Status: pin enable bit 7, protect hi bit 3, lo bit 2, latch bit 1.
// - Status bits 0, 4, 5, 6 are read-only zero.
// - Block protect bits are cleared to zero by reset, not retained.
// - Protect field selects none, upper quarter, upper half or whole array.
// - Pin enable set and protect pin low refuses status writes.
// - Protect pin never blocks array writes; cleared latch blocks all writes.
// - Status read command shifts out the status byte, reloaded and repeated while clocked.
// - Status write updates pin enable and protect bits, then clears latch.
// - Two address bytes MSB first; top bit ignored, low 15 bits used.
// - Each data byte written, address increments, wraps 7fff to 0000.
// - Byte commits on its eighth bit; partial bytes are dropped.
// - Burst reaching a protected address stops incrementing, drops later bytes.
// - After read command and address, drive byte MSB first, ignore input.
// - Reads continue sequentially with address increment and wrap.
// - Chip select rise ends a read and floats the output.
// - Set-latch is 06h, clear-latch 04h, first byte of a frame.
// - Sample input on rising clock, change output on falling clock, MSB first.
// - Invalid first byte: ignore rest of frame, keep output floating.
`timescale 1ns/10ps

module nvw_memory
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   output logic so_o,
   output logic so_oe_o,
   output logic write_latch_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   nvw_pkg::nvw_link_s ln_q, ln_d;
   nvw_pkg::nvw_sys_s sy_q, sy_d;
   logic [7:0] mem_q [nvw_pkg::MEM_DEPTH];
   logic frame_tog_q, so_q, oe_q;
   logic [14:0] mem_wa, addr_nx;
   logic [7:0] byte_in;
   logic mem_we, new_frame, byte_done, sr_try, status_load, rd_step, prot_now, cs_rise;

   // Status byte as seen by the master; unused bits stay zero
   function automatic logic [7:0] status_byte(input logic protect_pin_enable, input logic [1:0] bp, input logic write_latch_flag);
      logic [7:0] s;
      s = nvw_pkg::STATUS_RESET;
      s[nvw_pkg::PROTECT_PIN_ENABLE_POS] = protect_pin_enable;
      s[nvw_pkg::BLOCK_PROTECT_HI_POS] = bp[1];
      s[nvw_pkg::BLOCK_PROTECT_LO_POS] = bp[0];
      s[nvw_pkg::WRITE_LATCH_FLAG_POS] = write_latch_flag;
      return s;
   endfunction

   // Address falls in the block selected by the protect field
   function automatic logic is_protected(input logic [1:0] bp, input logic [14:0] a);
      return (bp == nvw_pkg::BP_NONE) ? 1'b0 : (bp == nvw_pkg::BP_QUARTER) ? (a >= nvw_pkg::PROT_QUARTER_BASE) :
         (bp == nvw_pkg::BP_HALF) ? (a >= nvw_pkg::PROT_HALF_BASE) : 1'b1;
   endfunction

   // ---------------------------------------------------------------
   // Frame marker
   // ---------------------------------------------------------------
   // Toggles on each chip select fall; settles a setup time before the
   // first serial clock edge, so the link side reads it directly.
   always_ff @(negedge cs_n_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         frame_tog_q <= 1'b0;
      end
      else
      begin
         frame_tog_q <= ~frame_tog_q;
      end
   end

   // ---------------------------------------------------------------
   // Link side: command decode on rising serial clock
   // ---------------------------------------------------------------
   assign prot_now = is_protected(ln_q.bp, ln_q.addr);

   always_comb
   begin
      ln_d = ln_q;
      mem_we = 1'b0;
      mem_wa = ln_q.addr;
      new_frame = 1'b0;
      sr_try = 1'b0;
      status_load = 1'b0;
      rd_step = 1'b0;
      ln_d.wel_s1 = sy_q.write_latch_flag;
      ln_d.wel_s2 = ln_q.wel_s1;
      ln_d.wp_s1 = wp_n_i;
      ln_d.wp_s2 = ln_q.wp_s1;
      // No serial edge arrives after a frame, so each frame is set up
      // on its own first edge instead of at chip select rise.
      if (ln_q.tog_seen != frame_tog_q)
      begin
         new_frame = 1'b1;
         ln_d.tog_seen = frame_tog_q;
         ln_d.phase = nvw_pkg::PH_OPCODE;
         ln_d.bitcnt = nvw_pkg::BIT_FIRST;
         ln_d.shreg = 8'h00;
         ln_d.drive = 1'b0;
         ln_d.act_set = 1'b0;
         ln_d.act_clr = 1'b0;
         ln_d.stop = 1'b0;
      end
      byte_in = {ln_d.shreg[6:0], si_i};
      ln_d.shreg = byte_in;
      byte_done = (ln_d.bitcnt == nvw_pkg::BIT_LAST);
      addr_nx = ln_d.addr + 15'h0001;
      if (ln_d.phase == nvw_pkg::PH_RD_DATA || ln_d.phase == nvw_pkg::PH_SR_READ)
      begin
         ln_d.obuf = {ln_d.obuf[6:0], 1'b0};
      end
      ln_d.bitcnt = ln_d.bitcnt + 3'h1;
      if (byte_done)
      begin
         case (ln_d.phase)
            nvw_pkg::PH_OPCODE:
            begin
               case (byte_in)
                  nvw_pkg::SET_WRITE_LATCH_CMD:
                  begin
                     ln_d.act_set = 1'b1;
                     ln_d.phase = nvw_pkg::PH_DONE;
                  end
                  nvw_pkg::CLEAR_WRITE_LATCH_CMD:
                  begin
                     ln_d.act_clr = 1'b1;
                     ln_d.phase = nvw_pkg::PH_DONE;
                  end
                  nvw_pkg::STATUS_READ_CMD:
                  begin
                     status_load = 1'b1;
                     ln_d.obuf = status_byte(ln_q.protect_pin_enable, ln_q.bp, ln_q.wel_s2);
                     ln_d.drive = 1'b1;
                     ln_d.phase = nvw_pkg::PH_SR_READ;
                  end
                  nvw_pkg::STATUS_WRITE_CMD:
                  begin
                     ln_d.act_clr = 1'b1;
                     ln_d.phase = nvw_pkg::PH_SR_WRITE;
                  end
                  nvw_pkg::MEM_READ_CMD:
                  begin
                     ln_d.is_read = 1'b1;
                     ln_d.phase = nvw_pkg::PH_ADDR_HI;
                  end
                  nvw_pkg::MEM_WRITE_CMD:
                  begin
                     ln_d.act_clr = 1'b1;
                     ln_d.is_read = 1'b0;
                     ln_d.phase = nvw_pkg::PH_ADDR_HI;
                  end
                  default:
                  begin
                     ln_d.phase = nvw_pkg::PH_IGNORE;
                  end
               endcase
            end
            nvw_pkg::PH_ADDR_HI:
            begin
               ln_d.addr = {byte_in[6:0], ln_d.addr[7:0]};
               ln_d.phase = nvw_pkg::PH_ADDR_LO;
            end
            nvw_pkg::PH_ADDR_LO:
            begin
               ln_d.addr = {ln_d.addr[14:8], byte_in};
               if (ln_d.is_read)
               begin
                  ln_d.obuf = mem_q[{ln_d.addr[14:8], byte_in}];
                  ln_d.drive = 1'b1;
                  ln_d.phase = nvw_pkg::PH_RD_DATA;
               end
               else
               begin
                  ln_d.phase = nvw_pkg::PH_WR_DATA;
               end
            end
            nvw_pkg::PH_WR_DATA:
            begin
               // Refused bytes are simply consumed until chip select rises
               if (!ln_d.stop && ln_q.wel_s2)
               begin
                  if (is_protected(ln_q.bp, ln_d.addr))
                  begin
                     ln_d.stop = 1'b1;
                  end
                  else
                  begin
                     mem_we = 1'b1;
                     mem_wa = ln_d.addr;
                     ln_d.addr = addr_nx;
                  end
               end
            end
            nvw_pkg::PH_RD_DATA:
            begin
               rd_step = 1'b1;
               ln_d.addr = addr_nx;
               ln_d.obuf = mem_q[addr_nx];
            end
            nvw_pkg::PH_SR_WRITE:
            begin
               sr_try = 1'b1;
               // Protect pin is ignored unless its enable bit is set
               if (ln_q.wel_s2 && !(ln_q.protect_pin_enable && !ln_q.wp_s2))
               begin
                  ln_d.protect_pin_enable = byte_in[nvw_pkg::PROTECT_PIN_ENABLE_POS];
                  ln_d.bp = {byte_in[nvw_pkg::BLOCK_PROTECT_HI_POS], byte_in[nvw_pkg::BLOCK_PROTECT_LO_POS]};
               end
               ln_d.phase = nvw_pkg::PH_DONE;
            end
            nvw_pkg::PH_SR_READ:
            begin
               ln_d.obuf = status_byte(ln_q.protect_pin_enable, ln_q.bp, ln_q.wel_s2);
            end
            nvw_pkg::PH_IGNORE, nvw_pkg::PH_DONE:
            begin
               ln_d.phase = ln_d.phase;
            end
            default:
            begin
               ln_d.phase = nvw_pkg::PH_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge sck_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ln_q <= '0;
         ln_q.phase <= nvw_pkg::PH_IGNORE;
         ln_q.addr <= nvw_pkg::ADDR_RESET;
         ln_q.bp <= nvw_pkg::BLOCK_PROTECT_RESET;
         ln_q.protect_pin_enable <= nvw_pkg::PROTECT_PIN_ENABLE_RESET;
         ln_q.wp_s1 <= 1'b1;
         ln_q.wp_s2 <= 1'b1;
      end
      else
      begin
         ln_q <= ln_d;
      end
   end

   // Array has no reset: its contents are the retained data
   always_ff @(posedge sck_i)
   begin
      if (mem_we)
      begin
         mem_q[mem_wa] <= byte_in;
      end
   end

   // ---------------------------------------------------------------
   // Serial output on falling clock
   // ---------------------------------------------------------------
   // Chip select high clears the drive at once; the frame check keeps a
   // stale drive from the last frame off the pin in mode 3.
   always_ff @(negedge sck_i or negedge rst_n_i or posedge cs_n_i)
   begin
      if (!rst_n_i || cs_n_i)
      begin
         so_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         so_q <= ln_q.obuf[7];
         oe_q <= ln_q.drive && (ln_q.tog_seen == frame_tog_q);
      end
   end

   assign so_o = so_q;
   assign so_oe_o = oe_q;

   // ---------------------------------------------------------------
   // System side: write latch, updated at chip select rise
   // ---------------------------------------------------------------
   assign cs_rise = sy_q.cs_s2 && !sy_q.cs_s3;

   always_comb
   begin
      sy_d = sy_q;
      sy_d.cs_s1 = cs_n_i;
      sy_d.cs_s2 = sy_q.cs_s1;
      sy_d.cs_s3 = sy_q.cs_s2;
      // Action flags are stable here: the serial clock is idle after the frame
      if (cs_rise && ln_q.act_clr)
      begin
         sy_d.write_latch_flag = 1'b0;
      end
      else if (cs_rise && ln_q.act_set)
      begin
         sy_d.write_latch_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sy_q <= '1;
         sy_q.write_latch_flag <= nvw_pkg::WRITE_LATCH_RESET;
      end
      else
      begin
         sy_q <= sy_d;
      end
   end

   assign write_latch_o = sy_q.write_latch_flag;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   latch_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cs_rise && ln_q.act_clr) |=> !sy_q.write_latch_flag)
      else $error("latch not cleared at frame end");
   latch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cs_rise && ln_q.act_set && !ln_q.act_clr) |=> sy_q.write_latch_flag)
      else $error("latch not set at frame end");
   latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cs_rise |=> $stable(sy_q.write_latch_flag))
      else $error("latch changed outside frame end");
   status_byte_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      status_load |=> (ln_q.obuf[6:4] == 3'h0) && !ln_q.obuf[0] && ln_q.obuf[3:2] == ln_q.bp
      && ln_q.obuf[1] == $past(ln_q.wel_s2) && ln_q.drive)
      else $error("status byte malformed");
   array_guard_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      mem_we |-> ln_q.wel_s2 && !prot_now && ln_q.phase == nvw_pkg::PH_WR_DATA && !ln_q.stop)
      else $error("array written while refused");
   write_step_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      mem_we |=> ln_q.addr == $past(ln_q.addr) + 15'h0001)
      else $error("write address did not step");
   burst_stop_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      (ln_q.stop && !new_frame) |=> $stable(ln_q.addr) && !$past(mem_we))
      else $error("burst continued into protected block");
   read_wrap_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      (rd_step && ln_q.addr == nvw_pkg::ADDR_LAST) |=> ln_q.addr == nvw_pkg::ADDR_RESET)
      else $error("read address did not wrap");
   sr_guard_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      (sr_try && ln_q.protect_pin_enable && !ln_q.wp_s2) |=> $stable(ln_q.bp) && $stable(ln_q.protect_pin_enable))
      else $error("status written while pin protected");
   ignore_quiet_a: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      ln_q.phase == nvw_pkg::PH_IGNORE |-> !ln_q.drive)
      else $error("output driven after invalid command");

endmodule

// [tb/nvw_spi_master.sv]
// SPI master model for the memory command layer, modes 0 and 3, 6 ns serial clock.
// Assumes the bench calls its frame tasks one at a time.
`timescale 1ns/10ps
module nvw_spi_master
(
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   logic oe_seen;
   logic mode3;

   initial
   begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      oe_seen = 1'b0;
      mode3 = 1'b0;
   end

   // ---------------------------------------------------------------
   // Frame tasks
   // ---------------------------------------------------------------
   // Clock stands at its idle level outside frames; one command per frame
   task automatic open_frame();
      cs_n_o = 1'b0;
      oe_seen = 1'b0;
      #3;
   endtask

   // Data set after the falling edge, output sampled on the rising edge;
   // a released output reads as the inverse of its last level. Fewer than
   // eight bits cut a byte short.
   task automatic xbyte(input logic [7:0] d, output logic [7:0] q, input int n = 8);
      for (int i = 7; i > 7 - n; i--)
      begin
         sck_o = 1'b0;
         si_o = d[i];
         #3;
         sck_o = 1'b1;
         q[i] = (so_oe_i === 1'b1) ? so_i : ~so_i;
         if (so_oe_i === 1'b1) oe_seen = 1'b1;
         #3;
      end
   endtask

   // Released data line shows the inverse, so a stale bit is never mistaken
   // Long gap lets the latch update land in the system domain
   task automatic close_frame();
      sck_o = mode3;
      #3;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #30;
   endtask

   // Idle level moves only while deselected, so no frame sees the stray edge
   task automatic set_mode(input logic m);
      mode3 = m;
      sck_o = m;
      #3;
   endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the memory command layer.
// Assumes the design's own assertions are active and the master model above.
`timescale 1ns/10ps
module tb_top;
   logic clk_i;
   logic rst_n_i;
   logic wp_n_i;
   logic sck;
   logic cs_n;
   logic si;
   logic so_o;
   logic so_oe_o;
   logic write_latch_o;
   logic [7:0] rx;
   int errors = 0;
   int comparisons = 0;

   nvw_memory i_nvw_memory (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .write_latch_o(write_latch_o));
   nvw_spi_master i_nvw_spi_master (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o));

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(op, rx);
      i_nvw_spi_master.close_frame();
   endtask

   task automatic status_read_cmd(input logic [7:0] exp);
      logic [7:0] q;
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(nvw_pkg::STATUS_READ_CMD, rx);
      i_nvw_spi_master.xbyte(8'h00, q);
      i_nvw_spi_master.close_frame();
      chk(q, exp, "status");
   endtask

   task automatic latch(input logic exp);
      chk({7'h00, write_latch_o}, {7'h00, exp}, "latch");
   endtask

   task automatic status_write_cmd(input logic en, input logic [7:0] d);
      if (en) cmd(nvw_pkg::SET_WRITE_LATCH_CMD);
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(nvw_pkg::STATUS_WRITE_CMD, rx);
      i_nvw_spi_master.xbyte(d, rx);
      i_nvw_spi_master.close_frame();
   endtask

   task automatic mem_wr(input logic en, input logic [15:0] a, input logic [7:0] d [$]);
      if (en) cmd(nvw_pkg::SET_WRITE_LATCH_CMD);
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(nvw_pkg::MEM_WRITE_CMD, rx);
      i_nvw_spi_master.xbyte(a[15:8], rx);
      i_nvw_spi_master.xbyte(a[7:0], rx);
      foreach (d[i]) i_nvw_spi_master.xbyte(d[i], rx);
      i_nvw_spi_master.close_frame();
   endtask

   // Input during read data carries the inverse pattern, which must be ignored
   task automatic mem_rd(input logic [15:0] a, input logic [7:0] e [$]);
      logic [7:0] q [$];
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(nvw_pkg::MEM_READ_CMD, rx);
      i_nvw_spi_master.xbyte(a[15:8], rx);
      i_nvw_spi_master.xbyte(a[7:0], rx);
      foreach (e[i])
      begin
         i_nvw_spi_master.xbyte(~e[i], rx);
         q.push_back(rx);
      end
      i_nvw_spi_master.close_frame();
      foreach (e[i]) chk(q[i], e[i], "read data");
      chk({7'h00, so_oe_o}, 8'h00, "output released");
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      latch(1'b0);
      status_read_cmd(8'h00);
      $display("test reset done");
   endtask

   task automatic t_latch();
      cmd(nvw_pkg::SET_WRITE_LATCH_CMD);
      latch(1'b1);
      status_read_cmd(8'h02);
      cmd(nvw_pkg::CLEAR_WRITE_LATCH_CMD);
      latch(1'b0);
      status_read_cmd(8'h00);
      status_write_cmd(1'b0, 8'h0c);
      status_read_cmd(8'h00);
      $display("test latch done");
   endtask

   task automatic t_mem();
      mem_wr(1'b1, 16'hffff, '{8'ha5, 8'h5a});
      latch(1'b0);
      mem_wr(1'b1, 16'h5fff, '{8'h11, 8'h22, 8'h33});
      mem_rd(16'hffff, '{8'ha5, 8'h5a});
      mem_rd(16'h5fff, '{8'h11, 8'h22, 8'h33});
      mem_wr(1'b0, 16'h0000, '{8'h77});
      mem_rd(16'h0000, '{8'h5a});
      $display("test memory done");
   endtask

   task automatic t_protect();
      status_write_cmd(1'b1, 8'h76);
      latch(1'b0);
      status_read_cmd(8'h04);
      mem_wr(1'b1, 16'h5fff, '{8'h44, 8'h55, 8'h66});
      mem_rd(16'h5fff, '{8'h44, 8'h22, 8'h33});
      status_write_cmd(1'b1, 8'h08);
      mem_wr(1'b1, 16'h3fff, '{8'h66, 8'h99});
      mem_rd(16'h3fff, '{8'h66});
      status_write_cmd(1'b1, 8'h0c);
      mem_wr(1'b1, 16'h0000, '{8'h99});
      mem_rd(16'h0000, '{8'h5a});
      $display("test protect done");
   endtask

   task automatic t_pin();
      status_write_cmd(1'b1, 8'h80);
      status_read_cmd(8'h80);
      @(posedge clk_i);
      wp_n_i <= 1'b0;
      status_write_cmd(1'b1, 8'h0c);
      latch(1'b0);
      status_read_cmd(8'h80);
      mem_wr(1'b1, 16'h0010, '{8'h3c});
      mem_rd(16'h0010, '{8'h3c});
      @(posedge clk_i);
      wp_n_i <= 1'b1;
      status_write_cmd(1'b1, 8'h00);
      status_read_cmd(8'h00);
      $display("test pin done");
   endtask

   // Mode 3 frames, with a memory write cut in mid-byte
   task automatic t_mode3();
      i_nvw_spi_master.set_mode(1'b1);
      mem_wr(1'b1, 16'h0020, '{8'h00, 8'h00});
      cmd(nvw_pkg::SET_WRITE_LATCH_CMD);
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(nvw_pkg::MEM_WRITE_CMD, rx);
      i_nvw_spi_master.xbyte(8'h00, rx);
      i_nvw_spi_master.xbyte(8'h20, rx);
      i_nvw_spi_master.xbyte(8'h5c, rx);
      i_nvw_spi_master.xbyte(8'hff, rx, 4);
      i_nvw_spi_master.close_frame();
      latch(1'b0);
      mem_rd(16'h0020, '{8'h5c, 8'h00});
      status_read_cmd(8'h00);
      i_nvw_spi_master.set_mode(1'b0);
      $display("test mode 3 done");
   endtask

   task automatic t_invalid();
      i_nvw_spi_master.open_frame();
      i_nvw_spi_master.xbyte(8'hff, rx);
      i_nvw_spi_master.xbyte(nvw_pkg::STATUS_READ_CMD, rx);
      i_nvw_spi_master.xbyte(8'h00, rx);
      i_nvw_spi_master.close_frame();
      chk({7'h00, i_nvw_spi_master.oe_seen}, 8'h00, "invalid opcode drove");
      status_read_cmd(8'h00);
      $display("test invalid done");
   endtask

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run is about fifty frames of under 400 ns each
   initial
   begin
      #200000;
      errors++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      rst_n_i = 1'b0;
      wp_n_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_reset();
      t_latch();
      t_mem();
      t_protect();
      t_pin();
      t_mode3();
      t_invalid();
      print_verdict();
   end
endmodule
